// >>> tmr_cfg.svh
// register addresses, field positions and reset values of the temperature
// monitor register bank; included by the package, whose macros the bank module uses
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// read addresses
`define TMR_RD_LOCAL_VAL    8'h00
`define TMR_RD_REM_VAL_HI   8'h01
`define TMR_RD_STATUS1      8'h02
`define TMR_RD_CFG1         8'h03
`define TMR_RD_RATE         8'h04
`define TMR_RD_LOC_HI       8'h05
`define TMR_RD_LOC_LO       8'h06
`define TMR_RD_REM_HI_H     8'h07
`define TMR_RD_REM_LO_H     8'h08
`define TMR_RD_REM_VAL_LO   8'h10
`define TMR_RD_STATUS2      8'h23
`define TMR_RD_R2_VAL_HI    8'h30
`define TMR_RD_R2_VAL_LO    8'h33
`define TMR_RD_MAKER        8'hfe
`define TMR_RD_REVISION     8'hff
// write-only addresses of the split registers and the one-shot
`define TMR_WR_CFG1         8'h09
`define TMR_WR_RATE         8'h0a
`define TMR_WR_LOC_HI       8'h0b
`define TMR_WR_LOC_LO       8'h0c
`define TMR_WR_REM_HI_H     8'h0d
`define TMR_WR_REM_LO_H     8'h0e
`define TMR_WR_ONE_SHOT     8'h0f
// shared read and write addresses
`define TMR_RW_REM_OFF_H    8'h11
`define TMR_RW_REM_OFF_L    8'h12
`define TMR_RW_REM_HI_L     8'h13
`define TMR_RW_REM_LO_L     8'h14
`define TMR_RW_REM_OVERTEMP_COMPARATOR_OUT    8'h19
`define TMR_RW_LOC_OVERTEMP_COMPARATOR_OUT    8'h20
`define TMR_RW_HYST         8'h21
`define TMR_RW_ALERT_CFG    8'h22
`define TMR_RW_CFG2         8'h24
`define TMR_RW_R2_HI_H      8'h31
`define TMR_RW_R2_LO_H      8'h32
`define TMR_RW_R2_OFF_H     8'h34
`define TMR_RW_R2_OFF_L     8'h35
`define TMR_RW_R2_HI_L      8'h36
`define TMR_RW_R2_LO_L      8'h37
`define TMR_RW_R2_OVERTEMP_COMPARATOR_OUT     8'h39

// reset values
`define TMR_RST_ZERO        8'h00
`define TMR_RST_LIMIT_HI    8'h55
`define TMR_RST_HYST        8'h0a
`define TMR_RST_RATE        8'h07
`define TMR_RST_ALERT_CFG   8'h01

// field positions
`define TMR_CFG1_BANK_BIT   3
`define TMR_CFG1_STBY_BIT   6
`define TMR_ACFG_SCL_BIT    7
`define TMR_ACFG_SDA_BIT    6
`define TMR_ACFG_MASK_BIT   5
`define TMR_ACFG_CNT_LSB    1
`define TMR_ACFG_CNT_MSB    3
`define TMR_ST1_CLR_LSB     2
`define TMR_ST1_CLR_MSB     6
`define TMR_ST2_CLR_LSB     2
`define TMR_ST2_CLR_MSB     4
`define TMR_ST2_ALERT_BIT   0

`endif

// >>> tmr_pkg.sv
// types shared by the temperature monitor register bank and its users
// assumes tmr_cfg.svh on the include path
package tmr_pkg;
  `include "tmr_cfg.svh"

  typedef logic [7:0] tmr_byte_t;

  // limits and offsets of one remote channel
  typedef struct packed {
    tmr_byte_t upperHigh;
    tmr_byte_t lowerHigh;
    tmr_byte_t upperLow;
    tmr_byte_t lowerLow;
    tmr_byte_t offsetHigh;
    tmr_byte_t offsetLow;
    tmr_byte_t overtempLimit;
  } tmr_remote_s;

  // settings software writes, handed to converter and comparators
  typedef struct packed {
    tmr_byte_t   configPrimary;
    tmr_byte_t   measureRate;
    tmr_byte_t   localUpper;
    tmr_byte_t   localLower;
    tmr_byte_t   localOvertemp;
    tmr_byte_t   hysteresis;
    tmr_byte_t   alertCfg;
    tmr_byte_t   configSecondary;
    tmr_remote_s remote1;
    tmr_remote_s remote2;
  } tmr_settings_s;

  // one completed measurement from the converter
  typedef struct packed {
    tmr_byte_t localValue;
    tmr_byte_t remote1High;
    tmr_byte_t remote1Low;
    tmr_byte_t remote2High;
    tmr_byte_t remote2Low;
    logic [4:0] cond1;  // status 1 bits 6:2 conditions present now
    logic [2:0] cond2;  // status 2 bits 4:2 conditions present now
  } tmr_meas_s;

  // byte-level requests from the serial protocol engine
  typedef struct packed {
    logic      wrValid;
    logic      wrFirst;  // first data byte of a write transaction
    tmr_byte_t wrData;
    logic      rdReq;
  } tmr_busreq_s;
endpackage

// >>> tmr_register_bank.sv
// register bank and control of a three-channel temperature monitor
// assumes a serial protocol engine on core_clk delivering bytes, and a
// converter delivering results on core_clk; no input needs synchronising
//
// Function
// - a write to 0x0f in standby starts one conversion on all channels
// - one-shot address stores nothing; its data byte is discarded
// - bits 3:1 codes 000/001/011/111 need one to four successive faults
// - consecutive-alert register at 0x22, resets to 0x01, count up to four
// - bit 7 enables clock-line timeout, bit 6 data-line timeout, both off
// - bit 5 masks internal alert conditions from the alert output
// - split registers have separate read and write addresses 03/09 to 08/0e
// - configuration 1 bit 3 steers shared remote addresses to channel two
// - fixed second-channel addresses 30 to 39 ignore the bank bit
// - high and overtemperature limits reset to 0x55, hysteresis 0x0a, rate 0x07, alert configuration 0x01, others zero
// - values, status and identification registers are read-only
// - first byte of a write loads the pointer, second writes the register
// - status read clears latched flags only once their condition is gone
`timescale 1ns/1ps

module tmr_register_bank
  import tmr_pkg::*;
#(
  parameter int                     NUM_REMOTE = 2,
  parameter tmr_pkg::tmr_byte_t     MAKER_CODE = 8'h5a, // arbitrary value
  parameter tmr_pkg::tmr_byte_t     REVISION   = 8'h01  // arbitrary value
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // protocol engine side
  input  wire tmr_pkg::tmr_busreq_s busReq,
  output logic [7:0]                rdData_r,
  output logic                      rdValid_r,
  // converter side
  input  wire logic                 measValid,
  input  wire tmr_pkg::tmr_meas_s   meas,
  input  wire logic                 convBusy,
  input  wire logic [1:0]           overtempCond,  // local, remote 1
  input  wire logic                 overtempCond2, // remote 2
  output logic                      oneShot_r,
  output tmr_pkg::tmr_settings_s    settings_r,
  // alert and bus timeout controls
  output logic                      alertAsserted_r,
  output logic                      sclTimeoutEn_r,
  output logic                      sdaTimeoutEn_r
);
  import tmr_pkg::*;

  initial begin
    if (NUM_REMOTE != 2) begin
      $error("tmr_register_bank serves exactly two remote channels");
    end
  end

  tmr_byte_t   pointer_r;
  tmr_byte_t   localVal_r;
  tmr_byte_t   remHigh_r [2];
  tmr_byte_t   remLow_r  [2];
  logic [4:0]  flags1_r;
  logic [2:0]  flags2_r;
  logic [2:0]  faultCnt_r;
  logic        alertLatch_r;

  logic        wrData;
  logic        bank;
  tmr_byte_t   wdat;
  tmr_remote_s remSel;
  tmr_byte_t   rdMux;
  logic [2:0]  needCnt;
  logic        anyFault;
  logic        rdSt1;
  logic        rdSt2;

  // second byte of a write reaches the selected register
  assign wrData  = busReq.wrValid && !busReq.wrFirst;
  assign wdat    = busReq.wrData;
  assign bank    = settings_r.configPrimary[`TMR_CFG1_BANK_BIT];
  assign remSel  = bank ? settings_r.remote2 : settings_r.remote1;
  assign rdSt1   = busReq.rdReq && pointer_r == `TMR_RD_STATUS1;
  assign rdSt2   = busReq.rdReq && pointer_r == `TMR_RD_STATUS2;
  assign anyFault = |meas.cond1 || |meas.cond2;

  // pointer: first byte of every write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_r <= `TMR_RST_ZERO;
    end else if (busReq.wrValid && busReq.wrFirst) begin
      pointer_r <= busReq.wrData;
    end
  end

  // writable settings; no case here stores the one-shot byte, and any
  // address absent from the chain falls through untouched
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settings_r.configPrimary   <= `TMR_RST_ZERO;
      settings_r.measureRate     <= `TMR_RST_RATE;
      settings_r.localUpper      <= `TMR_RST_LIMIT_HI;
      settings_r.localLower      <= `TMR_RST_ZERO;
      settings_r.localOvertemp   <= `TMR_RST_LIMIT_HI;
      settings_r.hysteresis      <= `TMR_RST_HYST;
      settings_r.alertCfg        <= `TMR_RST_ALERT_CFG;
      settings_r.configSecondary <= `TMR_RST_ZERO;
      settings_r.remote1 <= '{`TMR_RST_LIMIT_HI, `TMR_RST_ZERO,
                              `TMR_RST_ZERO, `TMR_RST_ZERO, `TMR_RST_ZERO,
                              `TMR_RST_ZERO, `TMR_RST_LIMIT_HI};
      settings_r.remote2 <= '{`TMR_RST_LIMIT_HI, `TMR_RST_ZERO,
                              `TMR_RST_ZERO, `TMR_RST_ZERO, `TMR_RST_ZERO,
                              `TMR_RST_ZERO, `TMR_RST_LIMIT_HI};
    end else if (wrData) begin
      if (pointer_r == `TMR_WR_CFG1) begin
        settings_r.configPrimary <= wdat;
      end else if (pointer_r == `TMR_WR_RATE) begin
        settings_r.measureRate <= wdat;
      end else if (pointer_r == `TMR_WR_LOC_HI) begin
        settings_r.localUpper <= wdat;
      end else if (pointer_r == `TMR_WR_LOC_LO) begin
        settings_r.localLower <= wdat;
      end else if (pointer_r == `TMR_WR_REM_HI_H) begin
        if (bank) settings_r.remote2.upperHigh <= wdat;
        else      settings_r.remote1.upperHigh <= wdat;
      end else if (pointer_r == `TMR_WR_REM_LO_H) begin
        if (bank) settings_r.remote2.lowerHigh <= wdat;
        else      settings_r.remote1.lowerHigh <= wdat;
      end else if (pointer_r == `TMR_RW_REM_OFF_H) begin
        if (bank) settings_r.remote2.offsetHigh <= wdat;
        else      settings_r.remote1.offsetHigh <= wdat;
      end else if (pointer_r == `TMR_RW_REM_OFF_L) begin
        if (bank) settings_r.remote2.offsetLow <= wdat;
        else      settings_r.remote1.offsetLow <= wdat;
      end else if (pointer_r == `TMR_RW_REM_HI_L) begin
        if (bank) settings_r.remote2.upperLow <= wdat;
        else      settings_r.remote1.upperLow <= wdat;
      end else if (pointer_r == `TMR_RW_REM_LO_L) begin
        if (bank) settings_r.remote2.lowerLow <= wdat;
        else      settings_r.remote1.lowerLow <= wdat;
      end else if (pointer_r == `TMR_RW_REM_OVERTEMP_COMPARATOR_OUT) begin
        if (bank) settings_r.remote2.overtempLimit <= wdat;
        else      settings_r.remote1.overtempLimit <= wdat;
      end else if (pointer_r == `TMR_RW_LOC_OVERTEMP_COMPARATOR_OUT) begin
        settings_r.localOvertemp <= wdat;
      end else if (pointer_r == `TMR_RW_HYST) begin
        settings_r.hysteresis <= wdat;
      end else if (pointer_r == `TMR_RW_ALERT_CFG) begin
        settings_r.alertCfg <= wdat;
      end else if (pointer_r == `TMR_RW_CFG2) begin
        settings_r.configSecondary <= wdat;
      end else if (pointer_r == `TMR_RW_R2_HI_H) begin
        settings_r.remote2.upperHigh <= wdat;
      end else if (pointer_r == `TMR_RW_R2_LO_H) begin
        settings_r.remote2.lowerHigh <= wdat;
      end else if (pointer_r == `TMR_RW_R2_OFF_H) begin
        settings_r.remote2.offsetHigh <= wdat;
      end else if (pointer_r == `TMR_RW_R2_OFF_L) begin
        settings_r.remote2.offsetLow <= wdat;
      end else if (pointer_r == `TMR_RW_R2_HI_L) begin
        settings_r.remote2.upperLow <= wdat;
      end else if (pointer_r == `TMR_RW_R2_LO_L) begin
        settings_r.remote2.lowerLow <= wdat;
      end else if (pointer_r == `TMR_RW_R2_OVERTEMP_COMPARATOR_OUT) begin
        settings_r.remote2.overtempLimit <= wdat;
      end
    end
  end

  // one-shot: the write itself is the trigger, only honoured in standby
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oneShot_r <= 1'b0;
    end else begin
      oneShot_r <= wrData && pointer_r == `TMR_WR_ONE_SHOT
                   && settings_r.configPrimary[`TMR_CFG1_STBY_BIT];
    end
  end

  // bus timeout enables follow the alert-count register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclTimeoutEn_r <= 1'b0;
      sdaTimeoutEn_r <= 1'b0;
    end else begin
      sclTimeoutEn_r <= settings_r.alertCfg[`TMR_ACFG_SCL_BIT];
      sdaTimeoutEn_r <= settings_r.alertCfg[`TMR_ACFG_SDA_BIT];
    end
  end

  // measured values, read-only from the bus side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      localVal_r  <= `TMR_RST_ZERO;
      remHigh_r[0] <= `TMR_RST_ZERO;
      remHigh_r[1] <= `TMR_RST_ZERO;
      remLow_r[0]  <= `TMR_RST_ZERO;
      remLow_r[1]  <= `TMR_RST_ZERO;
    end else if (measValid) begin
      localVal_r   <= meas.localValue;
      remHigh_r[0] <= meas.remote1High;
      remHigh_r[1] <= meas.remote2High;
      remLow_r[0]  <= meas.remote1Low;
      remLow_r[1]  <= meas.remote2Low;
    end
  end

  // latched flags: a read clears only flags whose cause has gone, and a
  // new measurement in the same cycle sets again (set wins)
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags1_r <= '0;
      flags2_r <= '0;
    end else begin
      flags1_r <= (flags1_r & ~({5{rdSt1}} & ~meas.cond1))
                  | ({5{measValid}} & meas.cond1);
      flags2_r <= (flags2_r & ~({3{rdSt2}} & ~meas.cond2))
                  | ({3{measValid}} & meas.cond2);
    end
  end

  // codes 000/001/011/111 need 1..4 faults; popcount plus one maps them
  assign needCnt = 3'(settings_r.alertCfg[`TMR_ACFG_CNT_LSB])
                 + 3'(settings_r.alertCfg[`TMR_ACFG_CNT_LSB + 1])
                 + 3'(settings_r.alertCfg[`TMR_ACFG_CNT_MSB]) + 3'h1;

  // consecutive fault counter saturates at four
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultCnt_r <= 3'h0;
    end else if (measValid) begin
      if (!anyFault) begin
        faultCnt_r <= 3'h0;
      end else if (faultCnt_r < 3'h4) begin
        faultCnt_r <= faultCnt_r + 3'h1;
      end
    end
  end

  // alert latch: set after enough successive faults, dropped once no
  // latched flag remains; service by address read is not modelled here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alertLatch_r <= 1'b0;
    end else if (measValid && anyFault
                 && (faultCnt_r + 3'h1) >= needCnt) begin
      alertLatch_r <= 1'b1;
    end else if (!(|flags1_r) && !(|flags2_r)) begin
      alertLatch_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alertAsserted_r <= 1'b0;
    end else begin
      alertAsserted_r <= alertLatch_r
                         && !settings_r.alertCfg[`TMR_ACFG_MASK_BIT];
    end
  end

  // read decode; write-only addresses and gaps read as zero
  always_comb begin
    rdMux = `TMR_RST_ZERO;
    if (pointer_r == `TMR_RD_LOCAL_VAL) begin
      rdMux = localVal_r;
    end else if (pointer_r == `TMR_RD_REM_VAL_HI) begin
      rdMux = remHigh_r[bank];
    end else if (pointer_r == `TMR_RD_STATUS1) begin
      rdMux = {convBusy, flags1_r, overtempCond};
    end else if (pointer_r == `TMR_RD_CFG1) begin
      rdMux = settings_r.configPrimary;
    end else if (pointer_r == `TMR_RD_RATE) begin
      rdMux = settings_r.measureRate;
    end else if (pointer_r == `TMR_RD_LOC_HI) begin
      rdMux = settings_r.localUpper;
    end else if (pointer_r == `TMR_RD_LOC_LO) begin
      rdMux = settings_r.localLower;
    end else if (pointer_r == `TMR_RD_REM_HI_H) begin
      rdMux = remSel.upperHigh;
    end else if (pointer_r == `TMR_RD_REM_LO_H) begin
      rdMux = remSel.lowerHigh;
    end else if (pointer_r == `TMR_RD_REM_VAL_LO) begin
      rdMux = remLow_r[bank];
    end else if (pointer_r == `TMR_RW_REM_OFF_H) begin
      rdMux = remSel.offsetHigh;
    end else if (pointer_r == `TMR_RW_REM_OFF_L) begin
      rdMux = remSel.offsetLow;
    end else if (pointer_r == `TMR_RW_REM_HI_L) begin
      rdMux = remSel.upperLow;
    end else if (pointer_r == `TMR_RW_REM_LO_L) begin
      rdMux = remSel.lowerLow;
    end else if (pointer_r == `TMR_RW_REM_OVERTEMP_COMPARATOR_OUT) begin
      rdMux = remSel.overtempLimit;
    end else if (pointer_r == `TMR_RW_LOC_OVERTEMP_COMPARATOR_OUT) begin
      rdMux = settings_r.localOvertemp;
    end else if (pointer_r == `TMR_RW_HYST) begin
      rdMux = settings_r.hysteresis;
    end else if (pointer_r == `TMR_RW_ALERT_CFG) begin
      rdMux = settings_r.alertCfg;
    end else if (pointer_r == `TMR_RD_STATUS2) begin
      rdMux = {3'h0, flags2_r, overtempCond2, alertAsserted_r};
    end else if (pointer_r == `TMR_RW_CFG2) begin
      rdMux = settings_r.configSecondary;
    end else if (pointer_r == `TMR_RD_R2_VAL_HI) begin
      rdMux = remHigh_r[1];
    end else if (pointer_r == `TMR_RW_R2_HI_H) begin
      rdMux = settings_r.remote2.upperHigh;
    end else if (pointer_r == `TMR_RW_R2_LO_H) begin
      rdMux = settings_r.remote2.lowerHigh;
    end else if (pointer_r == `TMR_RD_R2_VAL_LO) begin
      rdMux = remLow_r[1];
    end else if (pointer_r == `TMR_RW_R2_OFF_H) begin
      rdMux = settings_r.remote2.offsetHigh;
    end else if (pointer_r == `TMR_RW_R2_OFF_L) begin
      rdMux = settings_r.remote2.offsetLow;
    end else if (pointer_r == `TMR_RW_R2_HI_L) begin
      rdMux = settings_r.remote2.upperLow;
    end else if (pointer_r == `TMR_RW_R2_LO_L) begin
      rdMux = settings_r.remote2.lowerLow;
    end else if (pointer_r == `TMR_RW_R2_OVERTEMP_COMPARATOR_OUT) begin
      rdMux = settings_r.remote2.overtempLimit;
    end else if (pointer_r == `TMR_RD_MAKER) begin
      rdMux = MAKER_CODE;
    end else if (pointer_r == `TMR_RD_REVISION) begin
      rdMux = REVISION;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r  <= `TMR_RST_ZERO;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= busReq.rdReq;
      if (busReq.rdReq) begin
        rdData_r <= rdMux;
      end
    end
  end

endmodule // tmr_register_bank

// >>> tmr_register_bank_checker.sv
// port assertions for the temperature monitor register bank
// assumes core_clk rising edge and asynchronous active-low rst_n
`timescale 1ns/1ps

module tmr_register_bank_checker
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  // bus side
  input wire tmr_pkg::tmr_busreq_s   busReq,
  input wire logic                   rdValid_r,
  // settings and controls
  input wire logic                   oneShot_r,
  input wire tmr_pkg::tmr_settings_s settings_r,
  input wire logic                   alertAsserted_r,
  input wire logic                   sclTimeoutEn_r,
  input wire logic                   sdaTimeoutEn_r
);
  logic [7:0] ptr_r;
  logic       dataWr;
  logic       osHit;
  logic       roPtr;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      ptr_r <= 8'h00;
    else if (busReq.wrValid && busReq.wrFirst)
      ptr_r <= busReq.wrData;
  end
  assign dataWr = busReq.wrValid && !busReq.wrFirst;
  assign osHit  = dataWr && ptr_r == 8'h0f;
  // no write mapping here, so settings must hold
  assign roPtr  = ptr_r inside {[8'h00:8'h08], 8'h0f, 8'h10, [8'h15:8'h18],
                                8'h23, 8'h30, 8'h33, 8'hfe, 8'hff};

  property p_rd_lat;
    busReq.rdReq |=> rdValid_r;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_ptr_only;
    busReq.wrValid && busReq.wrFirst |=> $stable(settings_r);
  endproperty
  a_ptr_only: assert property (p_ptr_only) else $error("pointer wrote");
  property p_oneshot;
    osHit |=> oneShot_r == $past(settings_r.configPrimary[6]);
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot missed");
  property p_os_none;
    !osHit |=> !oneShot_r;
  endproperty
  a_os_none: assert property (p_os_none) else $error("stray one-shot");
  property p_ro;
    dataWr && roPtr |=> $stable(settings_r);
  endproperty
  a_ro: assert property (p_ro) else $error("ignored write stored");
  property p_acfg;
    dataWr && ptr_r == 8'h22 |=> settings_r.alertCfg == $past(busReq.wrData);
  endproperty
  a_acfg: assert property (p_acfg) else $error("alert cfg write lost");
  property p_split;
    dataWr && ptr_r == 8'h09 |=> settings_r.configPrimary == $past(busReq.wrData);
  endproperty
  a_split: assert property (p_split) else $error("config write lost");
  // enables are registered copies, so they trail the register by one edge
  property p_tmo;
    sclTimeoutEn_r == $past(settings_r.alertCfg[7]) &&
      sdaTimeoutEn_r == $past(settings_r.alertCfg[6]);
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout enable wrong");
  property p_mask;
    settings_r.alertCfg[5] && $past(settings_r.alertCfg[5]) |-> !alertAsserted_r;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert shown");
endmodule // tmr_register_bank_checker

bind tmr_register_bank tmr_register_bank_checker i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .busReq(busReq), .rdValid_r(rdValid_r),
  .oneShot_r(oneShot_r), .settings_r(settings_r),
  .alertAsserted_r(alertAsserted_r), .sclTimeoutEn_r(sclTimeoutEn_r),
  .sdaTimeoutEn_r(sdaTimeoutEn_r));

// >>> tmr_host_model.sv
// byte-level host standing in for the serial protocol engine
// assumes bytes are taken on the rising edge of core_clk
`timescale 1ns/1ps

module tmr_host_model
  import tmr_pkg::*;
(
  // clock
  input  wire logic            core_clk,
  // register bus
  output tmr_pkg::tmr_busreq_s busReq,
  input  wire logic [7:0]      rdData_r,
  input  wire logic            rdValid_r
);
  initial busReq = '{wrValid: 1'b0, wrFirst: 1'b0, wrData: 8'h00, rdReq: 1'b0};

  // released data shows the inverse, so a stale byte never looks valid
  task automatic put(input logic first, input logic [7:0] data);
    @(negedge core_clk);
    busReq.wrValid = 1'b1;
    busReq.wrFirst = first;
    busReq.wrData  = data;
    @(negedge core_clk);
    busReq.wrValid = 1'b0;
    busReq.wrData  = ~data;
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    put(1'b1, addr);
    put(1'b0, data);
  endtask

  task automatic read_reg(output logic [7:0] data, output logic ok);
    @(negedge core_clk);
    busReq.rdReq = 1'b1;
    @(negedge core_clk);
    busReq.rdReq = 1'b0;
    ok   = rdValid_r;
    data = rdData_r;
  endtask
endmodule // tmr_host_model

// >>> testbench.sv
// self-checking bench for the temperature monitor register bank
// assumes the host model and the checker are compiled before it
`timescale 1ns/1ps

module testbench;
  import tmr_pkg::*;
  localparam tmr_byte_t MAKER = 8'h3c; // arbitrary value
  localparam tmr_byte_t REV   = 8'h07; // arbitrary value
  localparam logic [7:0] HI55 [6] = '{8'h05, 8'h07, 8'h19, 8'h20, 8'h31, 8'h39};
  localparam logic [7:0] ACFG [5] = '{8'h00, 8'h02, 8'h06, 8'h0e, 8'h20};
  localparam int         NEED [5] = '{1, 2, 3, 4, 1};
  logic          core_clk      = 1'b0;
  logic          rst_n         = 1'b0;
  tmr_busreq_s   busReq;
  logic [7:0]    rdData_r;
  logic          rdValid_r;
  logic          measValid     = 1'b0;
  tmr_meas_s     meas          = '0;
  logic          convBusy      = 1'b0;
  logic [1:0]    overtempCond  = 2'b00;
  logic          overtempCond2 = 1'b0;
  logic          oneShot_r;
  tmr_settings_s settings_r;
  logic          alertAsserted_r;
  logic          sclTimeoutEn_r;
  logic          sdaTimeoutEn_r;
  logic [7:0]    mem [0:255];
  logic [4:0]    flags1        = 5'h00;
  logic [31:0]   lfsr          = 32'hda4e;
  int            n_mismatch    = 0;
  int            compares      = 0;

  always #12.5 core_clk = ~core_clk;

  tmr_register_bank #(.NUM_REMOTE(2), .MAKER_CODE(MAKER), .REVISION(REV)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .busReq(busReq), .rdData_r(rdData_r),
    .rdValid_r(rdValid_r), .measValid(measValid), .meas(meas),
    .convBusy(convBusy), .overtempCond(overtempCond),
    .overtempCond2(overtempCond2), .oneShot_r(oneShot_r),
    .settings_r(settings_r), .alertAsserted_r(alertAsserted_r),
    .sclTimeoutEn_r(sclTimeoutEn_r), .sdaTimeoutEn_r(sdaTimeoutEn_r));
  tmr_host_model i_host (.core_clk(core_clk), .busReq(busReq),
    .rdData_r(rdData_r), .rdValid_r(rdValid_r));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // banked place to its fixed second-channel address
  function automatic logic [7:0] home(input logic [7:0] a, input logic bank);
    if (!bank)
      return a;
    case (a)
      8'h01: return 8'h30;
      8'h07: return 8'h31;
      8'h08: return 8'h32;
      8'h10: return 8'h33;
      8'h11, 8'h12, 8'h13, 8'h14: return a + 8'h23;
      8'h19: return 8'h39;
      default: return a;
    endcase
  endfunction
  // read address a data byte lands on, 8'hff when it is dropped
  function automatic logic [7:0] landing(input logic [7:0] a);
    if (a inside {[8'h09:8'h0e]})
      return a - 8'h06;
    if (a inside {[8'h11:8'h14], 8'h19, [8'h20:8'h22], 8'h24, 8'h31, 8'h32,
                  [8'h34:8'h37], 8'h39})
      return a;
    return 8'hff;
  endfunction
  function automatic logic [7:0] expect_rd(input logic [7:0] a);
    logic [7:0] h;
    h = home(a, mem[8'h03][3]);
    if (h == 8'h02)
      return {convBusy, flags1, overtempCond};
    if (h == 8'h23)
      return {6'h00, overtempCond2, 1'b0};
    if (h inside {[8'h00:8'h08], [8'h10:8'h14], 8'h19, [8'h20:8'h24],
                  [8'h30:8'h37], 8'h39, 8'hfe, 8'hff})
      return mem[h];
    return 8'h00;
  endfunction

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] l;
    l = landing(a);
    i_host.write_reg(a, d);
    if (l != 8'hff)
      mem[home(l, mem[8'h03][3])] = d;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    logic       ok;
    i_host.put(1'b1, a);
    i_host.read_reg(d, ok);
    check("rdValid", 8'h01, {7'h00, ok});
    check($sformatf("reg %h", a), expect_rd(a), d);
  endtask
  // converter result; condition stays live after the pulse
  task automatic measure(input logic [4:0] c1);
    @(negedge core_clk);
    lfsr = step(lfsr);
    meas = {lfsr, lfsr[7:0], c1, 3'b000};
    {convBusy, overtempCond, overtempCond2} = lfsr[11:8];
    measValid = 1'b1;
    @(negedge core_clk);
    measValid = 1'b0;
    {mem[8'h00], mem[8'h01], mem[8'h10], mem[8'h30], mem[8'h33]} = meas[47:8];
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (HI55[i]) mem[HI55[i]] = 8'h55;
    {mem[8'h04], mem[8'h21], mem[8'h22]} = {8'h07, 8'h0a, 8'h01};
    {mem[8'hfe], mem[8'hff]} = {MAKER, REV};
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    check("alertCfg", 8'h01, settings_r.alertCfg);
    for (int a = 0; a < 64; a++) rd_chk(a[7:0]);
    rd_chk(8'hfe);
    rd_chk(8'hff);
    repeat (300) begin
      measure(5'h00);
      lfsr = step(lfsr);
      wr(&lfsr[7:5] ? 8'hfe : {2'b00, lfsr[5:0]}, lfsr[15:8]);
      rd_chk({2'b00, lfsr[21:16]});
      check("sclEn", {7'h00, mem[8'h22][7]}, {7'h00, sclTimeoutEn_r});
      check("sdaEn", {7'h00, mem[8'h22][6]}, {7'h00, sdaTimeoutEn_r});
    end
    for (int s = 0; s < 2; s++) begin
      wr(8'h09, {1'b0, s[0], 6'h00});
      wr(8'h0f, 8'hff);
      check("oneShot", {7'h00, s[0]}, {7'h00, oneShot_r});
      rd_chk(8'h0f);
      rd_chk(8'h03);
    end
    wr(8'h09, 8'h00);
    for (int c = 0; c < 5; c++) begin
      wr(8'h22, ACFG[c]);
      for (int k = 1; k <= NEED[c]; k++) begin
        measure(5'h01);
        repeat (2) @(negedge core_clk);
        check("alert", {7'h00, k == NEED[c] && c < 4},
              {7'h00, alertAsserted_r});
      end
      flags1 = 5'h01;
      rd_chk(8'h02);
      measure(5'h00);
      rd_chk(8'h02);
      flags1 = 5'h00;
      rd_chk(8'h02);
      repeat (3) @(negedge core_clk);
      check("alertClear", 8'h00, {7'h00, alertAsserted_r});
    end
    complete_run();
  end
endmodule // testbench
